/* verilog/hri_pkg.sv */
package hri_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 25;
  localparam int CNT_W       = 21;
  localparam int TRIG_MIN_US = 2000;
  localparam int DELAY_US    = 1800;
  localparam int ACQ_US      = 26000;
  localparam int ACQ_CC_US   = 29000;
  localparam int XFER_US     = 2000;
  localparam int GAP_US      = 35000;
  localparam int GAP_CC_US   = 40000;
  localparam int PULSE_US    = 100;
  localparam int DELAY_CYC   = (DELAY_US * 1000) / CLK_NS;
  localparam int ACQ_CYC     = (ACQ_US * 1000) / CLK_NS;
  localparam int ACQ_CC_CYC  = (ACQ_CC_US * 1000) / CLK_NS;
  localparam int XFER_CYC    = (XFER_US * 1000) / CLK_NS;
  localparam int GAP_CYC     = (GAP_US * 1000) / CLK_NS;
  localparam int GAP_CC_CYC  = (GAP_CC_US * 1000) / CLK_NS;
  localparam int PULSE_CYC   = (PULSE_US * 1000) / CLK_NS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK   = 4'h8;
  localparam logic [3:0] ADDR_STATE  = 4'hC;
  localparam int         CTRL_CC     = 0;
  localparam int         EV_W        = 6;
  localparam int         EV_START    = 0;
  localparam int         EV_ACQ      = 1;
  localparam int         EV_DONE     = 2;
  localparam int         EV_FAIL     = 3;
  localparam int         EV_IGNORED  = 4;
  localparam int         EV_CLEAR    = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CAUSE_PASS     = 3'h0,
    CAUSE_CHARGE   = 3'h1,
    CAUSE_OVERLOAD = 3'h2,
    CAUSE_HIGH     = 3'h3,
    CAUSE_LOW      = 3'h4,
    CAUSE_CONTACT  = 3'h5,
    CAUSE_PD       = 3'h6,
    CAUSE_RANGE    = 3'h7
  } hri_cause_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DELAY = 2'h1,
    ST_ACQ   = 2'h2,
    ST_XFER  = 2'h3
  } hri_fsm_t;

  typedef struct packed {
    logic pass_n;
    logic fail_n;
    logic aboveLimit_n;
    logic belowLimit_n;
    logic chargeFault_n;
    logic contactFault_n;
    logic partialDisFault_n;
  } hri_judge_t;

  localparam hri_judge_t JUDGE_IDLE = 7'h7F;

  typedef struct packed {
    logic [1:0]       startSync;
    logic [1:0]       clearSync;
    logic             startPrev;
    hri_fsm_t         fsm;
    logic [CNT_W-1:0] phaseCnt;
    logic [CNT_W-1:0] gapCnt;
    logic             gapOk;
    logic             ccRun;
    logic [CNT_W-1:0] doneCnt;
    logic [CNT_W-1:0] acqCnt;
    logic             doneOut_n;
    logic             acqOut_n;
    hri_cause_t       cause;
    hri_judge_t       judge;
    logic             testActive_n;
    logic             ccEn;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  mask;
    logic [31:0]      rdData;
  } hri_state_t;

  localparam hri_state_t RESET_STATE = '{
    startSync:    2'h3,
    clearSync:    2'h3,
    startPrev:    1'b1,
    fsm:          ST_IDLE,
    gapOk:        1'b1,
    doneOut_n:    1'b1,
    acqOut_n:     1'b1,
    cause:        CAUSE_PASS,
    judge:        JUDGE_IDLE,
    testActive_n: 1'b1,
    default:      '0
  };

endpackage

/* verilog/hri_handler.sv */
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

module hri_handler #(
  parameter logic [20:0] DELAY_CYC  = 21'(hri_pkg::DELAY_CYC),
  parameter logic [20:0] ACQ_CYC    = 21'(hri_pkg::ACQ_CYC),
  parameter logic [20:0] ACQ_CC_CYC = 21'(hri_pkg::ACQ_CC_CYC),
  parameter logic [20:0] XFER_CYC   = 21'(hri_pkg::XFER_CYC),
  parameter logic [20:0] GAP_CYC    = 21'(hri_pkg::GAP_CYC),
  parameter logic [20:0] GAP_CC_CYC = 21'(hri_pkg::GAP_CC_CYC),
  parameter logic [20:0] PULSE_CYC  = 21'(hri_pkg::PULSE_CYC)
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // handler pins
  input  wire logic                      startTrig_n,
  input  wire logic                      clear_n,
  output logic                           pass_n,
  output logic                           fail_n,
  output logic                           above_limit_n,
  output logic                           below_limit_n,
  output logic                           charge_fault_n,
  output logic                           contact_fault_n,
  output logic                           partial_dis_fault_n,
  output logic                           reserved1_n,
  output logic                           reserved2_n,
  output logic                           testActive_n,
  output logic                           test_done_n,
  output logic                           sample_taken_n,
  // measurement core
  input  wire hri_pkg::hri_cause_t       resultCause,
  // register port
  input  wire logic [hri_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]               regWrData,
  input  wire logic                      regWrStb,
  input  wire logic                      regRdStb,
  output logic [31:0]                    regRdData,
  // interrupt
  output logic                           irq
);

  hri_pkg::hri_state_t st_r;
  hri_pkg::hri_state_t st_nxt;

  // ----------------------------------------------------------------
  // result decode
  // ----------------------------------------------------------------
  function automatic hri_pkg::hri_judge_t judgeOf(input hri_pkg::hri_cause_t c);
    hri_pkg::hri_judge_t j;
    j = hri_pkg::JUDGE_IDLE;
    if (c == hri_pkg::CAUSE_PASS) begin
      j.pass_n = 1'b0;
    end else begin
      j.fail_n = 1'b0;
      case (c)
        hri_pkg::CAUSE_CHARGE:   j.chargeFault_n     = 1'b0;
        hri_pkg::CAUSE_OVERLOAD: j.aboveLimit_n      = 1'b0;
        hri_pkg::CAUSE_HIGH:     j.aboveLimit_n      = 1'b0;
        hri_pkg::CAUSE_LOW:      j.belowLimit_n      = 1'b0;
        hri_pkg::CAUSE_CONTACT:  j.contactFault_n    = 1'b0;
        hri_pkg::CAUSE_PD:       j.partialDisFault_n = 1'b0;
        default:                 j.fail_n            = 1'b0;
      endcase
    end
    return j;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                         startLow;
    logic                         trigEdge;
    logic                         clearAct;
    logic [hri_pkg::EV_W-1:0]     ev;
    logic [20:0]                  gapLimit;
    logic [20:0]                  acqLimit;
    startLow = 1'b0;
    trigEdge = 1'b0;
    clearAct = 1'b0;
    ev       = '0;
    gapLimit = GAP_CYC;
    acqLimit = ACQ_CYC;
    st_nxt   = st_r;

    // two-stage synchronisers on pins
    st_nxt.startSync = {st_r.startSync[0], startTrig_n};
    st_nxt.clearSync = {st_r.clearSync[0], clear_n};
    startLow = ~st_r.startSync[1];
    trigEdge = st_r.startPrev & startLow;
    st_nxt.startPrev = ~startLow;
    clearAct = ~st_r.clearSync[1];

    // minimum spacing between results
    if (st_r.ccRun) begin
      gapLimit = GAP_CC_CYC;
      acqLimit = ACQ_CC_CYC;
    end
    if (!st_r.gapOk) begin
      st_nxt.gapCnt = st_r.gapCnt + 21'h1;
      if (st_r.gapCnt >= gapLimit - 21'h1) begin
        st_nxt.gapOk = 1'b1;
      end
    end

    // strobe pulses
    if (st_r.doneCnt != '0) begin
      st_nxt.doneCnt = st_r.doneCnt - 21'h1;
    end
    if (st_r.acqCnt != '0) begin
      st_nxt.acqCnt = st_r.acqCnt - 21'h1;
    end

    // sequencer
    case (st_r.fsm)
      hri_pkg::ST_IDLE: begin
        if (trigEdge && st_r.gapOk) begin
          st_nxt.fsm          = hri_pkg::ST_DELAY;
          st_nxt.phaseCnt     = '0;
          st_nxt.gapOk        = 1'b0;
          st_nxt.gapCnt       = '0;
          st_nxt.ccRun        = st_r.ccEn;
          st_nxt.testActive_n = 1'b0;
          st_nxt.judge        = hri_pkg::JUDGE_IDLE;
          st_nxt.doneCnt      = '0;
          ev[hri_pkg::EV_START] = 1'b1;
        end else if (trigEdge) begin
          ev[hri_pkg::EV_IGNORED] = 1'b1;
        end
      end
      hri_pkg::ST_DELAY: begin
        ev[hri_pkg::EV_IGNORED] = trigEdge;
        st_nxt.phaseCnt = st_r.phaseCnt + 21'h1;
        if (st_r.phaseCnt >= DELAY_CYC - 21'h1) begin
          st_nxt.fsm      = hri_pkg::ST_ACQ;
          st_nxt.phaseCnt = '0;
        end
      end
      hri_pkg::ST_ACQ: begin
        ev[hri_pkg::EV_IGNORED] = trigEdge;
        st_nxt.phaseCnt = st_r.phaseCnt + 21'h1;
        if (st_r.phaseCnt >= acqLimit - 21'h1) begin
          st_nxt.fsm      = hri_pkg::ST_XFER;
          st_nxt.phaseCnt = '0;
          st_nxt.cause    = resultCause;
          st_nxt.judge    = judgeOf(resultCause);
          st_nxt.acqCnt   = PULSE_CYC;
          ev[hri_pkg::EV_ACQ] = 1'b1;
        end
      end
      hri_pkg::ST_XFER: begin
        ev[hri_pkg::EV_IGNORED] = trigEdge;
        st_nxt.phaseCnt = st_r.phaseCnt + 21'h1;
        if (st_r.phaseCnt >= XFER_CYC - 21'h1) begin
          st_nxt.fsm          = hri_pkg::ST_IDLE;
          st_nxt.phaseCnt     = '0;
          st_nxt.testActive_n = 1'b1;
          st_nxt.doneCnt      = PULSE_CYC;
          ev[hri_pkg::EV_DONE] = 1'b1;
          ev[hri_pkg::EV_FAIL] = ~st_r.judge.fail_n;
        end
      end
      default: begin
        st_nxt.fsm = hri_pkg::ST_IDLE;
      end
    endcase

    // external clear overrides the sequence
    if (clearAct) begin
      st_nxt.fsm          = hri_pkg::ST_IDLE;
      st_nxt.phaseCnt     = '0;
      st_nxt.judge        = hri_pkg::JUDGE_IDLE;
      st_nxt.testActive_n = 1'b1;
      st_nxt.doneCnt      = '0;
      st_nxt.acqCnt       = '0;
      ev                  = '0;
      ev[hri_pkg::EV_CLEAR] = 1'b1;
    end
    st_nxt.doneOut_n = (st_nxt.doneCnt == '0);
    st_nxt.acqOut_n  = (st_nxt.acqCnt == '0);

    // register writes; a new event wins over a clear
    if (regWrStb) begin
      case (regAddr)
        hri_pkg::ADDR_CTRL:   st_nxt.ccEn = regWrData[hri_pkg::CTRL_CC];
        hri_pkg::ADDR_STATUS: st_nxt.status = st_r.status & ~regWrData[hri_pkg::EV_W-1:0];
        hri_pkg::ADDR_MASK:   st_nxt.mask = regWrData[hri_pkg::EV_W-1:0];
        default:              st_nxt.ccEn = st_r.ccEn;
      endcase
    end
    st_nxt.status = st_nxt.status | ev;

    // register reads, data one cycle later
    if (regRdStb) begin
      case (regAddr)
        hri_pkg::ADDR_CTRL:   st_nxt.rdData = {31'h0, st_r.ccEn};
        hri_pkg::ADDR_STATUS: st_nxt.rdData = {26'h0, st_r.status};
        hri_pkg::ADDR_MASK:   st_nxt.rdData = {26'h0, st_r.mask};
        hri_pkg::ADDR_STATE:  st_nxt.rdData = {17'h0, st_r.judge, st_r.cause,
                                               st_r.fsm, st_r.testActive_n,
                                               st_r.gapOk, st_r.ccRun};
        default:              st_nxt.rdData = 32'h0;
      endcase
    end else begin
      st_nxt.rdData = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= hri_pkg::RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pass_n              = st_r.judge.pass_n;
  assign fail_n              = st_r.judge.fail_n;
  assign above_limit_n       = st_r.judge.aboveLimit_n;
  assign below_limit_n       = st_r.judge.belowLimit_n;
  assign charge_fault_n      = st_r.judge.chargeFault_n;
  assign contact_fault_n     = st_r.judge.contactFault_n;
  assign partial_dis_fault_n = st_r.judge.partialDisFault_n;
  assign reserved1_n         = 1'b1;
  assign reserved2_n         = 1'b1;
  assign testActive_n        = st_r.testActive_n;
  assign test_done_n         = st_r.doneOut_n;
  assign sample_taken_n      = st_r.acqOut_n;
  assign regRdData           = st_r.rdData;
  assign irq                 = |(st_r.status & st_r.mask);

endmodule
`default_nettype wire

/* testbench/hri_handler_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module hri_handler_asserts (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // handler pins
  input wire logic                       startTrig_n,
  input wire logic                       clear_n,
  input wire logic                       pass_n,
  input wire logic                       fail_n,
  input wire logic                       above_limit_n,
  input wire logic                       below_limit_n,
  input wire logic                       charge_fault_n,
  input wire logic                       contact_fault_n,
  input wire logic                       partial_dis_fault_n,
  input wire logic                       reserved1_n,
  input wire logic                       reserved2_n,
  input wire logic                       testActive_n,
  input wire logic                       test_done_n,
  input wire logic                       sample_taken_n,
  // core and register port
  input wire hri_pkg::hri_cause_t        resultCause,
  input wire logic [hri_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0]                regWrData,
  input wire logic                       regWrStb,
  input wire logic                       regRdStb,
  input wire logic [31:0]                regRdData,
  input wire logic                       irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [6:0] jd;
  assign jd = {pass_n, fail_n, above_limit_n, below_limit_n, charge_fault_n,
               contact_fault_n, partial_dis_fault_n};
  sequence s_low3(sig);
    !sig [*3] ##1 sig;
  endsequence
  property p_pass; !pass_n |-> jd == 7'h3F; endproperty
  property p_resv; reserved1_n && reserved2_n; endproperty
  property p_one; !fail_n |-> pass_n && $countones(~jd[4:0]) <= 1; endproperty
  property p_cause; !(&jd[4:0]) |-> !fail_n; endproperty
  property p_acq; $fell(sample_taken_n) |-> s_low3(sample_taken_n); endproperty
  property p_done; $rose(testActive_n) && clear_n |-> s_low3(test_done_n); endproperty
  property p_hold;
    testActive_n && $past(testActive_n) && clear_n && $past(clear_n) |-> $stable(jd);
  endproperty
  property p_data; $fell(sample_taken_n) |-> !testActive_n && (pass_n ^ fail_n); endproperty
  property p_time; $fell(testActive_n) |-> ##[25:30] ($fell(sample_taken_n) || !clear_n);
  endproperty
  property p_clr;
    !clear_n [*4] |-> jd == 7'h7F && testActive_n && test_done_n && sample_taken_n;
  endproperty
  property p_start; $fell(testActive_n) |-> jd == 7'h7F; endproperty
  a_pass: assert property (p_pass) else $error("pass with other line");
  a_resv: assert property (p_resv) else $error("reserved line active");
  a_one: assert property (p_one) else $error("bad cause lines");
  a_cause: assert property (p_cause) else $error("cause without reject");
  a_acq: assert property (p_acq) else $error("sample pulse width");
  a_done: assert property (p_done) else $error("end pulse width");
  a_hold: assert property (p_hold) else $error("judge changed idle");
  a_data: assert property (p_data) else $error("no result at sample");
  a_time: assert property (p_time) else $error("acquisition timing");
  a_clr: assert property (p_clr) else $error("clear not applied");
  a_start: assert property (p_start) else $error("judge kept at start");
endmodule
`default_nettype wire

/* testbench/hri_handler_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hri_handler_model #(
  parameter int TRIG_W = 80000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // bench commands
  input  wire logic fire,
  input  wire logic clearReq,
  // handler pins
  output logic      startTrig_n,
  output logic      clear_n
);
  int cnt;
  assign clear_n = !clearReq;
  assign startTrig_n = (cnt == 0);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
    end else if (fire && cnt == 0) begin
      cnt <= TRIG_W;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* testbench/hri_handler_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module hri_handler_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, reset, fire, clearReq, startTrig_n, clear_n, regWrStb, regRdStb, irq;
  logic pass_n, fail_n, above_limit_n, below_limit_n, charge_fault_n, contact_fault_n;
  logic partial_dis_fault_n, reserved1_n, reserved2_n, testActive_n, test_done_n;
  logic sample_taken_n;
  hri_pkg::hri_cause_t resultCause;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData, d, s;
  int          error_cnt, comparisons, cycles, i;
  wire logic [6:0] jd;
  assign jd = {pass_n, fail_n, above_limit_n, below_limit_n, charge_fault_n,
               contact_fault_n, partial_dis_fault_n};
  localparam logic [20:0] T_DLY = 21'h5;
  localparam logic [20:0] T_ACQ = 21'h14;
  localparam logic [20:0] T_ACC = 21'h19;
  localparam logic [20:0] T_XFR = 21'hA;
  localparam logic [20:0] T_GAP = 21'h32;
  localparam logic [20:0] T_GCC = 21'h3C;
  localparam logic [20:0] T_PLS = 21'h3;
  localparam int          T_TRG = 8;
  hri_handler #(.DELAY_CYC(T_DLY), .ACQ_CYC(T_ACQ), .ACQ_CC_CYC(T_ACC), .XFER_CYC(T_XFR),
    .GAP_CYC(T_GAP), .GAP_CC_CYC(T_GCC), .PULSE_CYC(T_PLS)) i_dut (.clk, .reset,
    .startTrig_n, .clear_n, .pass_n, .fail_n, .above_limit_n, .below_limit_n,
    .charge_fault_n, .contact_fault_n, .partial_dis_fault_n, .reserved1_n, .reserved2_n,
    .testActive_n, .test_done_n, .sample_taken_n, .resultCause, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .irq);
  hri_handler_model #(.TRIG_W(T_TRG)) i_model (.clk, .reset, .fire, .clearReq, .startTrig_n,
    .clear_n);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [6:0] ej(input hri_pkg::hri_cause_t c);
    case (c)
      hri_pkg::CAUSE_PASS:    return 7'h3F;
      hri_pkg::CAUSE_CHARGE:  return 7'h5B;
      hri_pkg::CAUSE_LOW:     return 7'h57;
      hri_pkg::CAUSE_CONTACT: return 7'h5D;
      hri_pkg::CAUSE_PD:      return 7'h5E;
      hri_pkg::CAUSE_RANGE:   return 7'h5F;
      default:                return 7'h4F;
    endcase
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(negedge clk);
    v = regRdData;
    @(posedge clk);
  endtask
  task automatic run(input hri_pkg::hri_cause_t c, input logic cc, input logic rt,
                     input logic clr, input logic [5:0] msk);
    int n;
    int ta;
    logic [5:0] es;
    wr(hri_pkg::ADDR_CTRL, {31'h0, cc});
    wr(hri_pkg::ADDR_MASK, {26'h0, msk});
    resultCause <= c;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    for (n = 0; n < 20 && testActive_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    n = 0;
    ta = 0;
    while (testActive_n === 1'b0 && n < 100) begin
      fire <= rt && n == 10;
      if (clr && n == 8) clearReq <= 1'b1;
      @(posedge clk);
      #1 n++;
      if (sample_taken_n === 1'b0 && ta == 0) ta = n;
    end
    es = clr ? 6'h21 : {2'h1, c != hri_pkg::CAUSE_PASS, 3'h7};
    if (!clr) begin
      `CHK("acq time", T_DLY + (cc ? T_ACC : T_ACQ), ta)
      `CHK("busy time", T_DLY + T_XFR + (cc ? T_ACC : T_ACQ), n)
      `CHK("judge", ej(c), jd)
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK("spacing", 1'b1, testActive_n)
      rd(hri_pkg::ADDR_STATE, d);
      `CHK("state", {17'h0, ej(c), c, 3'h1, cc}, {d[31:2], d[0]})
    end else begin
      repeat (30) @(posedge clk);
      `CHK("clear judge", 7'h7F, jd)
      clearReq <= 1'b0;
    end
    rd(hri_pkg::ADDR_STATUS, d);
    `CHK("status", es, d[5:0])
    `CHK("irq", |(es & msk), irq)
    wr(hri_pkg::ADDR_STATUS, 32'h0000003F);
    rd(hri_pkg::ADDR_STATUS, d);
    `CHK("status clr", 32'h0, d)
    `CHK("irq clr", 1'b0, irq)
    repeat (40) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {reset, fire, clearReq, regWrStb, regRdStb} = 5'h10;
    {regAddr, regWrData, resultCause} = '0;
    s = 32'h0000B3ED;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("idle lines", 8'hFF, {jd, testActive_n})
    rd(hri_pkg::ADDR_MASK, d);
    `CHK("mask reset", 32'h0, d)
    rd(4'h2, d);
    `CHK("unmapped", 32'h0, d)
    for (i = 0; i < 8; i++) run(hri_pkg::hri_cause_t'(i[2:0]), i[0], i == 0, 1'b0, 6'h04);
    for (i = 0; i < 6; i++) begin
      s = xs(s);
      run(hri_pkg::hri_cause_t'(s[2:0]), s[3], 1'b0, 1'b0, s[9:4]);
    end
    run(hri_pkg::CAUSE_HIGH, 1'b0, 1'b0, 1'b1, 6'h20);
    give_verdict();
  end
endmodule
bind hri_handler hri_handler_asserts i_chk (.clk, .reset, .startTrig_n, .clear_n, .pass_n,
  .fail_n, .above_limit_n, .below_limit_n, .charge_fault_n, .contact_fault_n,
  .partial_dis_fault_n, .reserved1_n, .reserved2_n, .testActive_n, .test_done_n,
  .sample_taken_n, .resultCause, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
  .irq);
`undef CHK
`default_nettype wire
